//--- core/asprf_dev.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - First completed read releases ready flag high.
// - Repeat reads return same stored result while the buffer is empty.
// - Idle-low clock swaps edges when select falls.
// - Host keeps clock idle high if select tied.
// - Read bits change after the shifting edge.
// - Input bits captured on the sampling edge.
// - Data line released after final sampling edge.
// - Host keeps master clock running outside standby.
// - Doubler bit selects accepted master clock range.
// - Reset low restores logic; exit needs clock.
// - Active-low select enables and frames the port.
module asprf_dev (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Serial pins.
	asprf_if.dev port,
	// Conversion results from the converter core.
	input wire logic [asprf_pkg::RESULT_W-1:0] result_in,
	input wire logic result_valid_in,
	output logic result_ready_out,
	// Configuration and status towards the converter core.
	output logic clock_doubler_sel_out,
	output logic modulator_rate_sel_hi_out,
	output logic modulator_rate_sel_lo_out,
	output logic mclk_in_range_out,
	output logic core_reset_out
);
	import asprf_pkg::*;

	logic sclk_q_r, cs_n_q_r, mclk_q_r, idle_low_r, core_rst_r, ready_n_r, mclk_ok_r, wr_ptr_r, rd_ptr_r, fifo_ready_r;
	logic sclk_rise, sclk_fall, cs_fall, mclk_rise, selected, drive_edge, sample_edge;
	asprf_phase_e phase_r, phase_nxt;
	logic [4:0] bit_cnt_r, bit_cnt_nxt;
	logic [CMD_W-1:0] cmd_sh_r, cmd_sh_nxt, cmd_word;
	logic [RESULT_W-1:0] out_sh_r, out_sh_nxt, result_r;
	logic dout_r, dout_nxt, dout_oe_r, dout_oe_nxt, cmd_done, read_done, cfg_we, push, load;
	logic [2:0] cfg_r;
	logic [RESULT_W-1:0] fifo_mem [FIFO_DEPTH];
	logic [1:0] fifo_cnt_r, fifo_cnt_nxt;
	logic [7:0] per_cnt_r, per_min, per_max;

	////////////////////////////////////////////////////////////////////////
	// Pin edges and edge roles.
	// Previous pin levels, kept through the core reset so edges stay true.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_q_r <= 1'b1;
			cs_n_q_r <= 1'b1;
			mclk_q_r <= 1'b0;
		end else begin
			sclk_q_r <= port.sclk;
			cs_n_q_r <= port.cs_n;
			mclk_q_r <= port.master_clock;
		end
	end

	// Edge decode; the select line gates the whole port.
	assign sclk_rise = port.sclk & ~sclk_q_r;
	assign sclk_fall = ~port.sclk & sclk_q_r;
	assign cs_fall = ~port.cs_n & cs_n_q_r;
	assign mclk_rise = port.master_clock & ~mclk_q_r;
	assign selected = ~port.cs_n;
	assign drive_edge = idle_low_r ? sclk_rise : sclk_fall;
	assign sample_edge = idle_low_r ? sclk_fall : sclk_rise;

	// The clock level seen as select falls sets the idle polarity; a tied select keeps idle high.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_low_r <= RST_IDLE_LOW;
		end else if (core_rst_r) begin
			idle_low_r <= RST_IDLE_LOW;
		end else if (cs_fall) begin
			idle_low_r <= ~port.sclk;
		end
	end

	// Reset pin holds the core; release waits for a master clock edge.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			core_rst_r <= 1'b1;
		end else if (!port.reset_n) begin
			core_rst_r <= 1'b1;
		end else if (mclk_rise) begin
			core_rst_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer.
	// Command byte assembly and frame ends.
	assign cmd_word = {cmd_sh_r[CMD_W-2:0], port.din};
	assign cmd_done = (phase_r == ASPRF_PH_CMD) & (bit_cnt_r == CMD_LAST_BIT);
	assign read_done = (phase_r == ASPRF_PH_READ) & selected & sample_edge & (bit_cnt_r == RESULT_LAST_BIT);
	assign cfg_we = selected & sample_edge & cmd_done & ~cmd_word[CMD_READ_BIT];

	// Next frame state: command bits in, then result bits out on a read.
	always_comb begin
		phase_nxt = phase_r;
		bit_cnt_nxt = bit_cnt_r;
		cmd_sh_nxt = cmd_sh_r;
		out_sh_nxt = out_sh_r;
		dout_nxt = dout_r;
		dout_oe_nxt = dout_oe_r;
		if (!selected) begin
			phase_nxt = ASPRF_PH_IDLE;
			bit_cnt_nxt = 5'h00;
			dout_oe_nxt = 1'b0;
		end else begin
			unique case (phase_r)
				ASPRF_PH_IDLE: begin
					if (sample_edge) begin
						phase_nxt = ASPRF_PH_CMD;
						bit_cnt_nxt = 5'h01;
						cmd_sh_nxt = cmd_word;
					end
				end
				ASPRF_PH_CMD: begin
					if (sample_edge) begin
						cmd_sh_nxt = cmd_word;
						bit_cnt_nxt = bit_cnt_r + 5'h01;
						if (cmd_done) begin
							bit_cnt_nxt = 5'h00;
							phase_nxt = cmd_word[CMD_READ_BIT] ? ASPRF_PH_READ : ASPRF_PH_IDLE;
							out_sh_nxt = result_r;
						end
					end
				end
				ASPRF_PH_READ: begin
					if (drive_edge) begin
						dout_nxt = out_sh_r[RESULT_W-1];
						out_sh_nxt = {out_sh_r[RESULT_W-2:0], 1'b0};
						dout_oe_nxt = 1'b1;
					end
					if (sample_edge) begin
						bit_cnt_nxt = bit_cnt_r + 5'h01;
						if (read_done) begin
							phase_nxt = ASPRF_PH_IDLE;
							bit_cnt_nxt = 5'h00;
							dout_oe_nxt = 1'b0;
						end
					end
				end
				default: phase_nxt = ASPRF_PH_IDLE;
			endcase
		end
	end

	// Frame registers.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_r <= ASPRF_PH_IDLE;
			bit_cnt_r <= 5'h00;
			cmd_sh_r <= '0;
			out_sh_r <= '0;
			dout_r <= 1'b0;
			dout_oe_r <= 1'b0;
		end else if (core_rst_r) begin
			phase_r <= ASPRF_PH_IDLE;
			bit_cnt_r <= 5'h00;
			dout_oe_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			cmd_sh_r <= cmd_sh_nxt;
			out_sh_r <= out_sh_nxt;
			dout_r <= dout_nxt;
			dout_oe_r <= dout_oe_nxt;
		end
	end

	// Configuration written by a write command.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_r <= RST_CFG;
		end else if (core_rst_r) begin
			cfg_r <= RST_CFG;
		end else if (cfg_we) begin
			cfg_r <= cmd_word[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result buffer, stored result and ready flag.
	// A new word is taken only between frames and only once the stored one was read, so none is lost.
	assign push = result_valid_in & fifo_ready_r;
	assign load = (fifo_cnt_r != 2'h0) & (phase_r == ASPRF_PH_IDLE) & ~core_rst_r & ready_n_r;
	assign fifo_cnt_nxt = fifo_cnt_r + {1'b0, push} - {1'b0, load};

	// Buffer storage, one writer per entry.
	for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
		always_ff @(posedge ref_clk_in) begin
			if (push && (wr_ptr_r == 1'(i))) begin
				fifo_mem[i] <= result_in;
			end
		end
	end

	// Buffer pointers and the registered ready towards the core.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			fifo_cnt_r <= 2'h0;
			fifo_ready_r <= 1'b0;
		end else if (core_rst_r) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			fifo_cnt_r <= 2'h0;
			fifo_ready_r <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ load;
			fifo_cnt_r <= fifo_cnt_nxt;
			fifo_ready_r <= (fifo_cnt_nxt != 2'h2);
		end
	end

	// Output update drops the flag; the first finished read raises it.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			result_r <= '0;
			ready_n_r <= RST_READY_N;
		end else if (core_rst_r) begin
			ready_n_r <= RST_READY_N;
		end else if (load) begin
			result_r <= fifo_mem[rd_ptr_r];
			ready_n_r <= 1'b0;
		end else if (read_done) begin
			ready_n_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master clock range monitor.
	// Accepted period window follows the doubler bit.
	assign per_min = cfg_r[CFG_DOUBLER_BIT] ? MCLK_X2_PER_MIN_CYC : MCLK_PER_MIN_CYC;
	assign per_max = cfg_r[CFG_DOUBLER_BIT] ? MCLK_X2_PER_MAX_CYC : MCLK_PER_MAX_CYC;

	// Period counted between rising edges; a stopped clock falls out of range.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			per_cnt_r <= 8'h00;
			mclk_ok_r <= 1'b0;
		end else if (mclk_rise) begin
			per_cnt_r <= 8'h01;
			mclk_ok_r <= (per_cnt_r >= per_min) && (per_cnt_r <= per_max);
		end else begin
			if (per_cnt_r != 8'hff) begin
				per_cnt_r <= per_cnt_r + 8'h01;
			end
			if (per_cnt_r > per_max) begin
				mclk_ok_r <= 1'b0;
			end
		end
	end

	// Pin and core-side outputs, all from flip-flops.
	assign port.dout = dout_r;
	assign port.dout_oe = dout_oe_r;
	assign port.ready_n = ready_n_r;
	assign result_ready_out = fifo_ready_r;
	assign clock_doubler_sel_out = cfg_r[CFG_DOUBLER_BIT];
	assign modulator_rate_sel_lo_out = cfg_r[CFG_RATE_LO_BIT];
	assign modulator_rate_sel_hi_out = cfg_r[CFG_RATE_HI_BIT];
	assign mclk_in_range_out = mclk_ok_r;
	assign core_reset_out = core_rst_r;
endmodule

`default_nettype wire

//--- core/asprf_host.sv
`timescale 1ns/10ps
`default_nettype none

// Controller end: drives select, serial clock, data in, master clock and reset.
module asprf_host (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Serial pins.
	asprf_if.host port,
	// Command request.
	input wire logic cmd_valid_in,
	input wire logic cmd_read_in,
	input wire logic [2:0] cmd_cfg_in,
	input wire logic idle_low_in,
	output logic cmd_ready_out,
	// Read answer and flag.
	output logic [asprf_pkg::RESULT_W-1:0] result_out,
	output logic result_valid_out,
	output logic data_ready_out
);
	import asprf_pkg::*;

	asprf_hstate_e st_r;
	logic [4:0] tmr_r;
	logic [4:0] mdiv_r;
	logic mclk_r;
	logic [5:0] nbit_r;
	logic [5:0] total_r;
	logic [CMD_W-1:0] tx_sh_r;
	logic [RESULT_W-1:0] rx_sh_r;
	logic idle_low_r;
	logic sclk_r;
	logic cs_n_r;
	logic din_r;
	logic reset_n_r;
	logic ready_r;
	logic rvalid_r;
	logic flag_r;
	logic tmr_done;
	logic last_bit;
	logic take;

	////////////////////////////////////////////////////////////////////////
	// Master clock, running at all times.

	// Half-period divider toggles the clock on each enable.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mdiv_r <= 5'h00;
			mclk_r <= 1'b0;
		end else if (mdiv_r == MCLK_HALF_CYC - 5'h01) begin
			mdiv_r <= 5'h00;
			mclk_r <= ~mclk_r;
		end else begin
			mdiv_r <= mdiv_r + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transfer sequencer.

	// Decode of timer, bit position and request hand-off.
	assign tmr_done = (tmr_r == 5'h00);
	assign last_bit = (nbit_r + 6'h01 == total_r);
	assign take = (st_r == ASPRF_H_IDLE) & cmd_valid_in;

	// Reset pulse, then frames of half-periods: A drives, B samples.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= ASPRF_H_RESET;
			tmr_r <= RESET_LOW_CYC;
			nbit_r <= 6'h00;
			total_r <= HOST_CMD_BITS;
			tx_sh_r <= '0;
			rx_sh_r <= '0;
			idle_low_r <= RST_IDLE_LOW;
			sclk_r <= 1'b1;
			cs_n_r <= 1'b1;
			din_r <= 1'b0;
			reset_n_r <= 1'b0;
			ready_r <= 1'b0;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= 1'b0;
			if (!tmr_done) begin
				tmr_r <= tmr_r - 5'h01;
			end
			unique case (st_r)
				ASPRF_H_RESET: begin
					if (tmr_done) begin
						reset_n_r <= 1'b1;
						tmr_r <= WAKE_CYC;
						st_r <= ASPRF_H_WAKE;
					end
				end
				ASPRF_H_WAKE: begin
					if (tmr_done) begin
						ready_r <= 1'b1;
						st_r <= ASPRF_H_IDLE;
					end
				end
				ASPRF_H_IDLE: begin
					sclk_r <= ~idle_low_in;
					idle_low_r <= idle_low_in;
					if (take) begin
						ready_r <= 1'b0;
						cs_n_r <= 1'b0;
						tx_sh_r <= {cmd_read_in, 4'h0, cmd_cfg_in};
						total_r <= cmd_read_in ? HOST_READ_BITS : HOST_CMD_BITS;
						nbit_r <= 6'h00;
						tmr_r <= CS_SETUP_CYC;
						st_r <= ASPRF_H_SETUP;
					end
				end
				ASPRF_H_SETUP, ASPRF_H_PHB: begin
					if (tmr_done) begin
						if (st_r == ASPRF_H_PHB && last_bit) begin
							tmr_r <= SCLK_HALF_CYC;
							st_r <= ASPRF_H_HOLD;
						end else begin
							if (st_r == ASPRF_H_PHB) begin
								nbit_r <= nbit_r + 6'h01;
							end
							sclk_r <= idle_low_r;
							din_r <= tx_sh_r[CMD_W-1];
							tx_sh_r <= {tx_sh_r[CMD_W-2:0], 1'b0};
							tmr_r <= SCLK_HALF_CYC;
							st_r <= ASPRF_H_PHA;
						end
					end
				end
				ASPRF_H_PHA: begin
					if (tmr_done) begin
						sclk_r <= ~idle_low_r;
						if (nbit_r >= HOST_CMD_BITS) begin
							rx_sh_r <= {rx_sh_r[RESULT_W-2:0], port.dout_line};
						end
						tmr_r <= SCLK_HALF_CYC;
						st_r <= ASPRF_H_PHB;
					end
				end
				ASPRF_H_HOLD: begin
					if (tmr_done) begin
						cs_n_r <= 1'b1;
						rvalid_r <= (total_r == HOST_READ_BITS);
						tmr_r <= SCLK_HALF_CYC;
						st_r <= ASPRF_H_GAP;
					end
				end
				ASPRF_H_GAP: begin
					if (tmr_done) begin
						ready_r <= 1'b1;
						st_r <= ASPRF_H_IDLE;
					end
				end
			endcase
		end
	end

	// Registered copy of the device ready flag, active high.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= ~port.ready_n;
		end
	end

	// Pin and user outputs, all from flip-flops.
	assign port.cs_n = cs_n_r;
	assign port.sclk = sclk_r;
	assign port.din = din_r;
	assign port.master_clock = mclk_r;
	assign port.reset_n = reset_n_r;
	assign cmd_ready_out = ready_r;
	assign result_out = rx_sh_r;
	assign result_valid_out = rvalid_r;
	assign data_ready_out = flag_r;
endmodule

`default_nettype wire

//--- core/asprf_if.sv
`timescale 1ns/10ps
`default_nettype none

// Serial pins between the converter port and its controller.
interface asprf_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;
	logic dout_line;
	logic master_clock;
	logic reset_n;
	logic ready_n;

	// The shared data line floats high when nobody drives it.
	assign dout_line = dout_oe ? dout : 1'b1;

	modport dev (input cs_n, input sclk, input din, input master_clock, input reset_n,
		output dout, output dout_oe, output ready_n);
	modport host (output cs_n, output sclk, output din, output master_clock, output reset_n,
		input dout_line, input ready_n);
endinterface

`default_nettype wire

//--- core/asprf_pkg.sv
`default_nettype none

package asprf_pkg;
	// Base clock and word layout.
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESULT_W = 24;
	localparam int CMD_W = 8;
	localparam int FIFO_DEPTH = 2;
	localparam int CMD_READ_BIT = 7;
	localparam int CFG_DOUBLER_BIT = 0;
	localparam int CFG_RATE_LO_BIT = 1;
	localparam int CFG_RATE_HI_BIT = 2;
	localparam logic [4:0] CMD_LAST_BIT = 5'h07;
	localparam logic [4:0] RESULT_LAST_BIT = 5'h17;
	localparam logic [5:0] HOST_CMD_BITS = 6'h08;
	localparam logic [5:0] HOST_READ_BITS = 6'h20;

	// Times in ns.
	localparam int SCLK_HALF_NS = 100;
	localparam int CS_SETUP_NS = 30;
	localparam int RESET_LOW_NS = 100;
	localparam int MCLK_HALF_NS = 200;
	localparam int MCLK_PER_MIN_NS = 400;
	localparam int MCLK_PER_MAX_NS = 2500;
	localparam int MCLK_X2_PER_MIN_NS = 200;
	localparam int MCLK_X2_PER_MAX_NS = 1250;

	// Cycle counts: least times round up, longest times round down.
	localparam logic [4:0] SCLK_HALF_CYC = 5'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] CS_SETUP_CYC = 5'((CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] RESET_LOW_CYC = 5'((RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] MCLK_HALF_CYC = 5'((MCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] WAKE_CYC = 5'(2 * ((MCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) + 2);
	localparam logic [7:0] MCLK_PER_MIN_CYC = 8'((MCLK_PER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MCLK_PER_MAX_CYC = 8'(MCLK_PER_MAX_NS / CLK_PERIOD_NS);
	localparam logic [7:0] MCLK_X2_PER_MIN_CYC = 8'((MCLK_X2_PER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MCLK_X2_PER_MAX_CYC = 8'(MCLK_X2_PER_MAX_NS / CLK_PERIOD_NS);

	// Values after reset.
	localparam logic RST_READY_N = 1'b1;
	localparam logic RST_IDLE_LOW = 1'b0;
	localparam logic [2:0] RST_CFG = 3'h0;

	// Device frame phases and host sequencer states.
	typedef enum logic [1:0] {ASPRF_PH_IDLE, ASPRF_PH_CMD, ASPRF_PH_READ} asprf_phase_e;
	typedef enum logic [2:0] {ASPRF_H_RESET, ASPRF_H_WAKE, ASPRF_H_IDLE, ASPRF_H_SETUP,
		ASPRF_H_PHA, ASPRF_H_PHB, ASPRF_H_HOLD, ASPRF_H_GAP} asprf_hstate_e;
endpackage

`default_nettype wire

//--- sim/asprf_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// Watches the serial pins between the converter port and its controller.
module asprf_assertions (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Serial pins.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic dout_line,
	input wire logic master_clock,
	input wire logic reset_n,
	input wire logic ready_n
);
	logic idle_r;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	////////////////////////////////////////////////////////////////////////////
	// Idle level of the serial clock, learnt while select is high, so both polarities are judged alike.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_r <= 1'b1;
		end else if (cs_n) begin
			idle_r <= sclk;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// The sampling edge returns the clock to its idle level; the shifting edge leaves it.
	sequence sample_edge_s;
		$changed(sclk) && sclk == idle_r && !cs_n;
	endsequence
	sequence mclk_half_s;
		##2 $stable(master_clock) [*8] ##1 $changed(master_clock);
	endsequence

	// Checks on the pins.
	flag_release_a: assert property ($rose(ready_n) |-> $fell(dout_oe))
		else $error("ready flag rose outside the end of a read");
	dout_shift_a: assert property ($changed(dout) && dout_oe && $past(dout_oe) |-> sclk != idle_r)
		else $error("read bit changed away from the shifting edge");
	din_setup_a: assert property (sample_edge_s |-> din == $past(din) && din == $past(din, 2))
		else $error("input bit not settled before sampling edge");
	line_release_a: assert property ($fell(dout_oe) && !cs_n |->
		$past(sclk, 2) != idle_r && sclk == idle_r && dout_line)
		else $error("data line not released right after the final sampling edge");
	idle_quiet_a: assert property (cs_n [*3] |-> !dout_oe)
		else $error("data line driven while deselected");
	cs_setup_a: assert property ($fell(cs_n) |-> $stable(sclk) [*2])
		else $error("serial clock moved too soon after select");
	sclk_high_a: assert property ($rose(sclk) && !cs_n |-> sclk [*5])
		else $error("serial clock high too short");
	sclk_low_a: assert property ($fell(sclk) && !cs_n |-> !sclk [*5])
		else $error("serial clock low too short");
	mclk_run_a: assert property ($changed(master_clock) |-> mclk_half_s)
		else $error("master clock half period wrong");
	reset_flag_a: assert property (!reset_n [*3] |-> ready_n)
		else $error("ready flag low while device reset held");
endmodule

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// Joins both ends and drives them through their user sides.
module tb_top;
	import asprf_pkg::*;
	typedef struct {
		logic idle_low;
		logic [2:0] cfg;
		logic [RESULT_W-1:0] word;
		logic in_range;
	} asprf_row_s;
	logic ref_clk_in;
	logic rst_in;
	logic [RESULT_W-1:0] result_in;
	logic result_valid_in;
	logic result_ready_out;
	logic clock_doubler_sel_out;
	logic modulator_rate_sel_hi_out;
	logic modulator_rate_sel_lo_out;
	logic mclk_in_range_out;
	logic core_reset_out;
	logic cmd_valid_in;
	logic cmd_read_in;
	logic [2:0] cmd_cfg_in;
	logic idle_low_in;
	logic cmd_ready_out;
	logic [RESULT_W-1:0] result_out;
	logic result_valid_out;
	logic data_ready_out;
	logic [3:0] flags;
	logic [RESULT_W-1:0] seen;
	int err_count;
	int n_tests;
	asprf_row_s rows [4] = '{'{1'b0, 3'h0, 24'ha5c3f1, 1'b1}, '{1'b1, 3'h5, 24'h000001, 1'b1},
		'{1'b0, 3'h2, 24'h800000, 1'b1}, '{1'b1, 3'h7, 24'h5a5a5a, 1'b1}};

	asprf_if bus ();
	asprf_dev i_asprf_dev (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .port(bus), .result_in(result_in),
		.result_valid_in(result_valid_in), .result_ready_out(result_ready_out),
		.clock_doubler_sel_out(clock_doubler_sel_out), .modulator_rate_sel_hi_out(modulator_rate_sel_hi_out),
		.modulator_rate_sel_lo_out(modulator_rate_sel_lo_out), .mclk_in_range_out(mclk_in_range_out),
		.core_reset_out(core_reset_out));
	asprf_host i_asprf_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .port(bus), .cmd_valid_in(cmd_valid_in),
		.cmd_read_in(cmd_read_in), .cmd_cfg_in(cmd_cfg_in), .idle_low_in(idle_low_in),
		.cmd_ready_out(cmd_ready_out), .result_out(result_out), .result_valid_out(result_valid_out),
		.data_ready_out(data_ready_out));
	asprf_assertions i_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cs_n(bus.cs_n), .sclk(bus.sclk),
		.din(bus.din), .dout(bus.dout), .dout_oe(bus.dout_oe), .dout_line(bus.dout_line),
		.master_clock(bus.master_clock), .reset_n(bus.reset_n), .ready_n(bus.ready_n));

	// Flags that the bounded waits poll.
	assign flags = {result_ready_out, data_ready_out, result_valid_out, cmd_ready_out};

	////////////////////////////////////////////////////////////////////////////
	// Clock source.
	initial begin
		ref_clk_in = 1'b0;
		forever #(CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;
	end

	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic check(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	// Waits at falling edges for one flag, giving up after a bound.
	task automatic wait_flag(input int k);
		int i;
		for (i = 0; i < 3000 && flags[k] !== 1'b1; i++) begin
			@(negedge ref_clk_in);
		end
		if (flags[k] !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t: wait ran out", $time);
			give_verdict();
		end
	endtask

	// Hands one command to the controller while it is ready.
	task automatic host_cmd(input logic rd, input logic [2:0] cfg);
		wait_flag(0);
		cmd_read_in = rd;
		cmd_cfg_in = cfg;
		cmd_valid_in = 1'b1;
		@(negedge ref_clk_in);
		cmd_valid_in = 1'b0;
	endtask

	// Runs one read frame and keeps the word.
	task automatic host_read();
		host_cmd(1'b1, 3'h0);
		wait_flag(1);
		seen = result_out;
	endtask

	// Offers one word to the port; the caller lowers valid.
	task automatic push(input logic [RESULT_W-1:0] w);
		wait_flag(3);
		result_in = w;
		result_valid_in = 1'b1;
		@(negedge ref_clk_in);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rst_in = 1'b1;
		result_in = '0;
		result_valid_in = 1'b0;
		cmd_valid_in = 1'b0;
		cmd_read_in = 1'b0;
		cmd_cfg_in = 3'h0;
		idle_low_in = 1'b0;
		err_count = 0;
		n_tests = 0;
		repeat (2) @(negedge ref_clk_in);
		check(24'(core_reset_out), 24'h1);
		check(24'({result_ready_out, modulator_rate_sel_hi_out, modulator_rate_sel_lo_out, clock_doubler_sel_out,
			mclk_in_range_out, cmd_ready_out, data_ready_out}), 24'h0);
		repeat (2) @(negedge ref_clk_in);
		rst_in = 1'b0;
		// Each row: set polarity and mode, offer a word, read it twice.
		for (int r = 0; r < 4; r++) begin
			wait_flag(0);
			idle_low_in = rows[r].idle_low;
			repeat (2) @(negedge ref_clk_in);
			host_cmd(1'b0, rows[r].cfg);
			wait_flag(0);
			check(24'({modulator_rate_sel_hi_out, modulator_rate_sel_lo_out, clock_doubler_sel_out}),
				24'(rows[r].cfg));
			check(24'(mclk_in_range_out), 24'(rows[r].in_range));
			push(rows[r].word);
			result_valid_in = 1'b0;
			wait_flag(2);
			host_read();
			check(seen, rows[r].word);
			repeat (4) @(negedge ref_clk_in);
			check(24'(data_ready_out), 24'h0);
			host_read();
			check(seen, rows[r].word);
		end
		// Words arriving during a frame wait in the buffer until it refuses.
		host_cmd(1'b1, 3'h0);
		repeat (20) @(negedge ref_clk_in);
		push(24'h222222);
		push(24'h333333);
		result_valid_in = 1'b0;
		@(negedge ref_clk_in);
		check(24'(result_ready_out), 24'h0);
		wait_flag(1);
		check(result_out, 24'h5a5a5a);
		wait_flag(3);
		wait_flag(2);
		host_read();
		check(seen, 24'h222222);
		check(24'(data_ready_out), 24'h1);
		host_read();
		check(seen, 24'h333333);
		// A second reset in mid-run clears the flag and the mode.
		push(24'h444444);
		result_valid_in = 1'b0;
		wait_flag(2);
		rst_in = 1'b1;
		@(negedge ref_clk_in);
		check(24'({core_reset_out, data_ready_out, clock_doubler_sel_out, result_ready_out}), 24'h8);
		rst_in = 1'b0;
		wait_flag(0);
		check(24'({core_reset_out, data_ready_out}), 24'h0);
		give_verdict();
	end
endmodule

`default_nettype wire
